// ===== verilog/mdx_pkg.sv
// package: memory map ranges, vector addresses and priority constants
package mdx_pkg;
	localparam int ADDR_W = 24;
	localparam int NSRC = 29;
	localparam int LVL_W = 2;
	// region one-hot positions
	localparam int REG_ROM = 0;
	localparam int REG_RAM = 1;
	localparam int REG_IO = 2;
	localparam int REG_DISP = 3;
	localparam int REG_FONT = 4;
	localparam int REG_EXT = 5;
	localparam int NREG = 6;
	// address ranges
	localparam logic [23:0] ROM_LO = 24'h000000;
	localparam logic [23:0] ROM_HI = 24'h00bfff;
	localparam logic [23:0] RAM_LO = 24'h00d800;
	localparam logic [23:0] RAM_HI = 24'h00f7ff;
	localparam logic [23:0] IO_LO = 24'h00ff00;
	localparam logic [23:0] IO_HI = 24'h00ffff;
	localparam logic [23:0] FONT_LO = 24'h010000;
	localparam logic [23:0] FONT_HI = 24'h03ffff;
	localparam logic [15:0] DISP_PAGE = 16'h00f0;
	localparam logic [3:0] DISP_X_LO = 4'h8;
	localparam logic [3:0] DISP_X_HI = 4'hd;
	localparam logic [7:0] DISP_OFF_HI = 8'h4f;
	// vectors
	localparam logic [23:0] VEC_LO = 24'h000000;
	localparam logic [23:0] VEC_HI = 24'h00003b;
	localparam logic [23:0] VEC_RSV0 = 24'h000026;
	localparam logic [23:0] VEC_RSV1 = 24'h00003c;
	localparam logic [23:0] SWI_LO = 24'h00003e;
	localparam logic [23:0] SWI_HI = 24'h0000ff;
	localparam logic [7:0] VEC_STEP = 8'h02;
	// source index of first timer and serial slots (index*2 = vector below index 19, index*2+2 from 19 on)
	localparam int SRC_RESET = 0;
	localparam int SRC_TIMER0 = 11;
	localparam int SRC_SERIAL = 20;
	// 512K regions supported by the core
	localparam int REGION_W = 19;
	localparam int NREGION = 4;
endpackage : mdx_pkg

// ===== verilog/mdx_prio_arb.sv
// fixed-order arbiter within the highest programmed priority level
`timescale 1ns/100ps
module mdx_prio_arb #(
	parameter int N = 29,
	parameter int LW = 2
) (
	input wire logic [N-1:0] req, // pending sources, bit 0 highest
	input wire logic [N*LW-1:0] lvl, // programmed level per source
	output logic any, // some source pending
	output logic [$clog2(N)-1:0] idx // winning source index
);
	initial begin
		if (N < 2 || LW < 1) $error("mdx_prio_arb: bad parameters");
	end

	always_comb begin
		logic [LW-1:0] best;
		logic found;
		best = '0;
		found = 1'b0;
		idx = '0;
		// higher level wins; ties go to lower index
		for (int i = 0; i < N; i++) begin
			if (req[i] && (!found || lvl[i*LW +: LW] > best)) begin
				found = 1'b1;
				best = lvl[i*LW +: LW];
				idx = i[$clog2(N)-1:0];
			end
		end
		any = found;
	end
endmodule : mdx_prio_arb

// ===== verilog/mdx_decode.sv
// memory map decoder and exception vector unit
`timescale 1ns/100ps
module mdx_decode #(
	parameter int NSRC = mdx_pkg::NSRC,
	parameter int LVL_W = mdx_pkg::LVL_W
) (
	input wire logic clk, // cpu clock
	input wire logic rstn, // synchronous reset, active low
	input wire logic chip_mode_pin, // high keeps internal rom
	input wire logic [23:0] cpu_addr, // physical address
	input wire logic cpu_req, // access strobe
	input wire logic [NSRC-1:0] exc_req, // exception requests, bit 0 reset
	input wire logic [NSRC*LVL_W-1:0] exc_lvl, // programmed levels
	input wire logic exc_ack, // cpu starts servicing the pending vector
	input wire logic swi_req, // software interrupt request
	input wire logic [7:0] swi_vec, // software vector address low byte
	output logic [mdx_pkg::NREG-1:0] region_sel, // one-hot region select
	output logic [1:0] region_num, // 512K region of the access
	output logic rom_mapped, // latched chip mode
	output logic vec_valid, // vector address pending
	output logic [23:0] vec_addr, // vector address of winner
	output logic vec_push, // push flags and pc first
	output logic vec_rsv_err, // reserved slot or bad swi vector
	output logic custom_condition_flag // never driven high
);
	initial begin
		if (NSRC != mdx_pkg::NSRC || LVL_W < 1) $error("mdx_decode: bad parameters");
	end

	// ----------------------------------------------------------------
	// chip mode capture
	// ----------------------------------------------------------------
	// caught on the first clock after release so reset never loads a pin
	logic in_reset;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			in_reset <= 1'b1;
		end else begin
			in_reset <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rom_mapped <= 1'b1;
		end else if (in_reset) begin
			rom_mapped <= chip_mode_pin;
		end
	end

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	logic hit_rom, hit_ram, hit_io, hit_disp, hit_font;
	logic [mdx_pkg::NREG-1:0] next_region_sel;
	always_comb begin
		hit_rom = rom_mapped && cpu_addr <= mdx_pkg::ROM_HI;
		hit_ram = cpu_addr >= mdx_pkg::RAM_LO && cpu_addr <= mdx_pkg::RAM_HI;
		hit_io = cpu_addr >= mdx_pkg::IO_LO && cpu_addr <= mdx_pkg::IO_HI;
		hit_disp = cpu_addr[23:12] == mdx_pkg::DISP_PAGE[15:4]
			&& cpu_addr[11:8] >= mdx_pkg::DISP_X_LO && cpu_addr[11:8] <= mdx_pkg::DISP_X_HI
			&& cpu_addr[7:0] <= mdx_pkg::DISP_OFF_HI;
		hit_font = rom_mapped && cpu_addr >= mdx_pkg::FONT_LO && cpu_addr <= mdx_pkg::FONT_HI;
		next_region_sel = '0;
		if (cpu_req) begin
			// internal ranges first so overlapping external memory never answers
			if (hit_io) next_region_sel[mdx_pkg::REG_IO] = 1'b1;
			else if (hit_disp) next_region_sel[mdx_pkg::REG_DISP] = 1'b1;
			else if (hit_ram) next_region_sel[mdx_pkg::REG_RAM] = 1'b1;
			else if (hit_rom) next_region_sel[mdx_pkg::REG_ROM] = 1'b1;
			else if (hit_font) next_region_sel[mdx_pkg::REG_FONT] = 1'b1;
			else next_region_sel[mdx_pkg::REG_EXT] = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			region_sel <= '0;
			region_num <= 2'h0;
		end else begin
			region_sel <= next_region_sel;
			region_num <= cpu_addr[mdx_pkg::REGION_W +: 2];
		end
	end

	// ----------------------------------------------------------------
	// exception priority and vector generation
	// ----------------------------------------------------------------
	logic arb_any;
	logic [$clog2(NSRC)-1:0] arb_idx;
	mdx_prio_arb #(.N(NSRC), .LW(LVL_W)) u_arb (
		.req(exc_req),
		.lvl(exc_lvl),
		.any(arb_any),
		.idx(arb_idx)
	);

	// table index i maps to vector i*2, or (i+1)*2 from index 19 on; timers, serial, stopwatch and clock
	// timer follow in table order, skipping the reserved slot 0x26 after index 18
	function automatic logic [23:0] src_vec(input logic [$clog2(NSRC)-1:0] i);
		logic [7:0] slot;
		slot = {3'h0, i};
		if (slot >= 8'(mdx_pkg::SRC_SERIAL - 1))
			slot = slot + 8'h01;
		return {16'h0000, slot * mdx_pkg::VEC_STEP};
	endfunction : src_vec

	logic swi_ok;
	always_comb begin
		swi_ok = !swi_vec[0] && {16'h0000, swi_vec} >= mdx_pkg::SWI_LO;
	end

	typedef enum logic [1:0] {
		MDX_IDLE = 2'b00,
		MDX_PEND = 2'b01
	} mdx_state_t;
	mdx_state_t state;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state <= MDX_IDLE;
			vec_valid <= 1'b0;
			vec_addr <= 24'h000000;
			vec_push <= 1'b0;
			vec_rsv_err <= 1'b0;
		end else begin
			case (state)
				MDX_IDLE: begin
					vec_rsv_err <= 1'b0;
					if (arb_any) begin
						state <= MDX_PEND;
						vec_valid <= 1'b1;
						vec_addr <= src_vec(arb_idx);
						vec_push <= arb_idx != mdx_pkg::SRC_RESET[$clog2(NSRC)-1:0];
					end else if (swi_req) begin
						// unranked: taken only when no hardware source waits
						if (swi_ok) begin
							state <= MDX_PEND;
							vec_valid <= 1'b1;
							vec_addr <= {16'h0000, swi_vec};
							vec_push <= 1'b1;
						end else begin
							vec_rsv_err <= 1'b1;
						end
					end
				end
				MDX_PEND: begin
					// cpu reads low byte at vec_addr, high byte at vec_addr+1
					if (exc_ack) begin
						state <= MDX_IDLE;
						vec_valid <= 1'b0;
						vec_push <= 1'b0;
					end
				end
				default: begin
					state <= MDX_IDLE;
					vec_valid <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		custom_condition_flag <= 1'b0;
	end
endmodule : mdx_decode

// ===== testbench/mdx_decode_sva.sv
// checker: decode and vector port assertions
`timescale 1ns/100ps
module mdx_decode_sva (
	input wire logic clk, // clock
	input wire logic rstn, // reset
	input wire logic [23:0] cpu_addr, // address
	input wire logic cpu_req, // strobe
	input wire logic exc_ack, // ack
	input wire logic [5:0] region_sel, // select
	input wire logic [1:0] region_num, // region
	input wire logic rom_mapped, // mode
	input wire logic vec_valid, // pending
	input wire logic [23:0] vec_addr, // vector
	input wire logic vec_push, // push
	input wire logic custom_condition_flag // flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire ram = cpu_addr >= 24'h00d800 && cpu_addr <= 24'h00f7ff;
	wire font = cpu_addr >= 24'h010000 && cpu_addr <= 24'h03ffff;
	ram_sel_a: assert property (cpu_req && ram |=> region_sel == 6'h02) else $error("ram decode");
	io_sel_a: assert property (cpu_req && cpu_addr[23:8] == 16'h00ff |=> region_sel == 6'h04) else $error("io");
	rom_sel_a: assert property (cpu_req && cpu_addr <= 24'h00bfff |=> region_sel == (rom_mapped ? 6'h01 : 6'h20))
		else $error("rom decode");
	font_sel_a: assert property (cpu_req && font |=> region_sel == (rom_mapped ? 6'h10 : 6'h20))
		else $error("font decode");
	one_sel_a: assert property (cpu_req |=> $onehot(region_sel)) else $error("select not one-hot");
	num_ok_a: assert property (cpu_req |=> region_num == $past(cpu_addr[20:19])) else $error("region num");
	ccf_low_a: assert property (custom_condition_flag == 1'b0) else $error("flag driven");
	vec_hold_a: assert property (vec_valid && !exc_ack |=> vec_valid && $stable(vec_addr)) else $error("hold");
	ack_drop_a: assert property (vec_valid && exc_ack |=> !vec_valid) else $error("no drop");
	push_rule_a: assert property (vec_valid |-> vec_push == (vec_addr != 24'h0)) else $error("push");
	rsv_slot_a: assert property (vec_valid |-> vec_addr != 24'h26 && vec_addr != 24'h3c && !vec_addr[0])
		else $error("reserved slot");
	cover property (vec_valid && vec_addr == 24'h0);
	cover property (cpu_req && !rom_mapped);
	cover property (vec_valid && exc_ack);
endmodule : mdx_decode_sva
bind mdx_decode mdx_decode_sva i_sva (.clk, .rstn, .cpu_addr, .cpu_req, .exc_ack, .region_sel, .region_num,
	.rom_mapped, .vec_valid, .vec_addr, .vec_push, .custom_condition_flag);

// ===== testbench/mdx_cpu_model.sv
// cpu side model: takes pending vectors promptly or slowly
`timescale 1ns/100ps
module mdx_cpu_model (
	input wire logic clk, // clock
	input wire logic vec_valid, // pending
	input wire logic slow, // stretch fetch
	output logic exc_ack // taken
);
	int cnt = 0;
	initial exc_ack = 1'b0;
	// both vector bytes are fetched before the ack
	always @(negedge clk) begin
		exc_ack <= 1'b0;
		if (vec_valid && !exc_ack) begin
			cnt <= cnt + 1;
			if (cnt >= (slow ? 6 : 1)) begin
				exc_ack <= 1'b1;
				cnt <= 0;
			end
		end
	end
endmodule : mdx_cpu_model

// ===== testbench/testbench.sv
// testbench: decode, mode latch, vectors, priority
`timescale 1ns/100ps
module testbench;
	logic clk = 0, rstn = 0, chip_mode_pin = 1, cpu_req = 0, swi_req = 0, slow = 0, mode = 1, pv = 0;
	logic [23:0] cpu_addr = 24'h0, vec_addr, a;
	logic [28:0] exc_req = '0;
	logic [57:0] exc_lvl = '0;
	logic [7:0] swi_vec = 8'h3e;
	logic [5:0] region_sel;
	logic [1:0] region_num;
	logic rom_mapped, vec_valid, vec_push, vec_rsv_err, custom_condition_flag, exc_ack;
	logic [7:0] exp_reg[$];
	logic [24:0] exp_vec[$], e;
	logic [31:0] x = 32'h00011e5f;
	int n_errors = 0, checks = 0, i, k;
	localparam logic [23:0] TBL [13] = '{24'h0, 24'h00bfff, 24'h00c000, 24'h00d800, 24'h00f7ff, 24'h00f800,
		24'h00fd4f, 24'h00f850, 24'h00ff00, 24'h00ffff, 24'h010000, 24'h03ffff, 24'h040000};
	mdx_decode i_mdx_decode (.clk, .rstn, .chip_mode_pin, .cpu_addr, .cpu_req, .exc_req, .exc_lvl, .exc_ack,
		.swi_req, .swi_vec, .region_sel, .region_num, .rom_mapped, .vec_valid, .vec_addr, .vec_push,
		.vec_rsv_err, .custom_condition_flag);
	mdx_cpu_model i_mdx_cpu_model (.clk, .vec_valid, .slow, .exc_ack);
	initial forever #25 clk = ~clk;
	function logic [5:0] region(input logic [23:0] d);
		if (d[23:8] == 16'h00ff) return 6'h04;
		if (d[23:12] == 12'h00f && d[11:8] >= 4'h8 && d[11:8] <= 4'hd && d[7:0] <= 8'h4f) return 6'h08;
		if (d >= 24'h00d800 && d <= 24'h00f7ff) return 6'h02;
		if (mode && d <= 24'h00bfff) return 6'h01;
		if (mode && d >= 24'h010000 && d <= 24'h03ffff) return 6'h10;
		return 6'h20;
	endfunction : region
	task fail(input string s, input logic [24:0] ev, input logic [24:0] sv);
		n_errors++;
		$display("unexpected %s: expected %h seen %h", s, ev, sv);
	endtask : fail
	task summarize();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : summarize
	task rst(input logic p);
		@(negedge clk);
		rstn = 0;
		chip_mode_pin = p;
		mode = p;
		repeat (3) @(negedge clk);
		rstn = 1;
		repeat (3) @(negedge clk);
		checks++;
		if (rom_mapped !== p) fail("rom_mapped", p, rom_mapped);
		checks++;
		if (custom_condition_flag !== 1'b0) fail("custom_condition_flag", 0, custom_condition_flag);
	endtask : rst
	task run_map();
		for (k = 0; k < 43; k++) begin
			@(negedge clk);
			x ^= x << 13;
			x ^= x >> 17;
			x ^= x << 5;
			// bits 20:19 vary so the region number is exercised
			a = k < 13 ? TBL[k] : {3'h0, x[20:0]};
			cpu_addr = a;
			cpu_req = 1;
			exp_reg.push_back({a[20:19], region(a)});
		end
		@(negedge clk);
		cpu_req = 0;
		@(negedge clk);
	endtask : run_map
	task exc(input logic [28:0] r, input logic [57:0] l, input logic s, input logic [7:0] v);
		@(negedge clk);
		exc_req = r;
		exc_lvl = l;
		swi_req = s;
		swi_vec = v;
		exp_vec.push_back({v != 8'h0, 16'h0, v});
		for (k = 0; k < 40 && exc_ack !== 1'b1; k++) @(negedge clk);
		if (k == 40) begin
			fail("ack wait", 1, 0);
			summarize();
		end
		exc_req = '0;
		swi_req = 0;
		repeat (2) @(negedge clk);
	endtask : exc
	always @(negedge clk) begin
		if (region_sel !== 6'h00) begin
			checks++;
			e = exp_reg.size() ? exp_reg.pop_front() : '1;
			if ({region_num, region_sel} !== e[7:0]) fail("region", e, {region_num, region_sel});
		end
		if (vec_valid === 1'b1 && !pv) begin
			checks++;
			e = exp_vec.size() ? exp_vec.pop_front() : '1;
			if ({vec_push, vec_addr} !== e) fail("vector", e, {vec_push, vec_addr});
		end
		pv = vec_valid === 1'b1;
	end
	initial begin
		rst(1'b1);
		run_map();
		for (i = 0; i < 29; i++) begin
			slow = i[0];
			exc(29'h1 << i, '0, 0, i < 19 ? 8'(2 * i) : 8'(2 * i + 2));
		end
		exc('1, '0, 0, 8'h0);
		exc(29'h10000008, '0, 0, 8'h06);
		exc(29'h00100020, 58'h1 << 40, 0, 8'h2a);
		exc('0, '0, 1, 8'h3e);
		@(negedge clk);
		swi_req = 1;
		swi_vec = 8'h3d;
		for (k = 0; k < 3 && vec_rsv_err !== 1'b1; k++) @(negedge clk);
		checks++;
		if (k == 3) begin
			fail("vec_rsv_err", 1, vec_rsv_err);
			summarize();
		end
		swi_req = 0;
		rst(1'b0);
		run_map();
		chip_mode_pin = 1;
		run_map();
		checks++;
		if (rom_mapped !== 1'b0 || exp_reg.size() || exp_vec.size()) fail("leftover", 0, rom_mapped);
		summarize();
	end
endmodule : testbench
